// ### shared/bse_map.vh
// Constants for the block and sector erase decoder
`ifndef BSE_MAP_VH
`define BSE_MAP_VH

// ---------------------------------------------------------------
// Command opcodes and framing
// ---------------------------------------------------------------
`define BSE_OP_BLOCK_ERASE 8'h50
`define BSE_OP_SECTOR_ERASE 8'h7c
`define BSE_CMD_BITS 6'd32
`define BSE_CNT_MAX 6'h3f

// ---------------------------------------------------------------
// Address field positions within the 24 address bits
// ---------------------------------------------------------------
`define BSE_STD_PAGE_MSB 23
`define BSE_STD_PAGE_LSB 9
`define BSE_BIN_PAGE_MSB 22
`define BSE_BIN_PAGE_LSB 8

// ---------------------------------------------------------------
// Page ranges of erase units
// ---------------------------------------------------------------
`define BSE_BLOCK_OFFSET_MASK 15'h0007
`define BSE_SECTOR_OFFSET_MASK 15'h03ff
`define BSE_SEC0A_FIRST 15'h0000
`define BSE_SEC0A_LAST 15'h0007
`define BSE_SEC0B_FIRST 15'h0008
`define BSE_SEC0B_LAST 15'h03ff
`define BSE_SEC0A_BLOCK 12'h000
`define BSE_SEC0B_BLOCK 12'h001
`define BSE_SEC_ZERO 5'h00

// ---------------------------------------------------------------
// Erased contents and reset values
// ---------------------------------------------------------------
`define BSE_ERASED_BYTE 8'hff
`define BSE_RST_READY 1'b1
`define BSE_RST_ERROR 1'b0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define BSE_CLK_PERIOD_NS 8
`define BSE_BLOCK_ERASE_TIME_NS 2000
`define BSE_SECTOR_ERASE_TIME_NS 8000

`endif

// ### hdl/bse_sync.v
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bse_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire clk_i,              // Block clock
    input wire rst_i,              // Synchronous reset
    input wire [WIDTH-1:0] d_i,    // Asynchronous inputs
    output wire [WIDTH-1:0] q_o    // Synchronised outputs
);
    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] stable;

    // First stage feeds only the second stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta <= RESET_VAL;
            stable <= RESET_VAL;
        end else begin
            meta <= d_i;
            stable <= meta;
        end
    end

    assign q_o = stable;
endmodule // bse_sync

// ### hdl/bse_page_mem.v
// Page contents store, one representative word per page
`timescale 1ns/1ps
module bse_page_mem #(
    parameter WIDTH = 8,
    parameter AW = 15
) (
    input wire clk_i,                // Block clock
    input wire we_i,                 // Write enable
    input wire [AW-1:0] waddr_i,     // Write page
    input wire [WIDTH-1:0] wdata_i,  // Write data
    input wire [AW-1:0] raddr_i,     // Read page
    output reg [WIDTH-1:0] rdata_o   // Registered read data
);
    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule // bse_page_mem

// ### hdl/bse_erase.v
// Block and sector erase command decoder and self-timed erase sequencer
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
`include "bse_map.vh"
module bse_erase #(
    parameter AW = 15,
    parameter DW = 8,
    parameter CLK_PERIOD_NS = `BSE_CLK_PERIOD_NS,
    parameter BLOCK_ERASE_TIME_NS = `BSE_BLOCK_ERASE_TIME_NS,
    parameter SECTOR_ERASE_TIME_NS = `BSE_SECTOR_ERASE_TIME_NS
) (
    input wire clk_i,                        // Block clock, 125 MHz
    input wire rst_i,                        // Synchronous reset, active high
    input wire sck_i,                        // Serial clock pin
    input wire cs_n_i,                       // Chip select pin, active low
    input wire si_i,                         // Serial data in pin
    input wire binary_page_mode_i,           // 1: 256-byte pages, 0: 264-byte pages
    input wire weak_en_i,                    // Enable the weak-page fault
    input wire [AW-1:0] weak_page_i,         // Page that refuses to erase
    input wire load_we_i,                    // Preload one page word while idle
    input wire [AW-1:0] load_page_i,         // Preload page
    input wire [DW-1:0] load_data_i,         // Preload data
    input wire [AW-1:0] peek_page_i,         // Page to observe while idle
    output reg [DW-1:0] peek_data_o,         // Observed page word
    output reg ready_busy_flag_o,            // 1: ready, 0: busy
    output reg erase_program_error_flag_o    // Last erase had a failure
);
    // ---------------------------------------------------------------
    // Timing counts (longest times, rounded down, at least one cycle)
    // ---------------------------------------------------------------
    localparam integer BE_RAW = BLOCK_ERASE_TIME_NS / CLK_PERIOD_NS;
    localparam integer SE_RAW = SECTOR_ERASE_TIME_NS / CLK_PERIOD_NS;
    localparam integer BE_CYC = (BE_RAW < 1) ? 1 : BE_RAW;
    localparam integer SE_CYC = (SE_RAW < 1) ? 1 : SE_RAW;
    localparam [23:0] BE_CNT = BE_CYC[23:0];
    localparam [23:0] SE_CNT = SE_CYC[23:0];

    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_PULSE = 3'd1;
    localparam [2:0] ST_WRITE = 3'd2;
    localparam [2:0] ST_READ = 3'd3;
    localparam [2:0] ST_CHECK = 3'd4;

    // ---------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ---------------------------------------------------------------
    wire [2:0] pins_s;
    wire sck_s;
    wire cs_n_s;
    wire si_s;
    reg sck_d;
    reg cs_n_d;

    bse_sync #(
        .WIDTH(3),
        .RESET_VAL(3'b010)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({sck_i, cs_n_i, si_i}),
        .q_o(pins_s)
    );

    assign sck_s = pins_s[2];
    assign cs_n_s = pins_s[1];
    assign si_s = pins_s[0];

    always @(posedge clk_i) begin
        if (rst_i) begin
            sck_d <= 1'b0;
            cs_n_d <= 1'b1;
        end else begin
            sck_d <= sck_s;
            cs_n_d <= cs_n_s;
        end
    end

    wire sck_rise = sck_s & ~sck_d;
    wire cs_fall = ~cs_n_s & cs_n_d;
    wire cs_rise = cs_n_s & ~cs_n_d;

    // ---------------------------------------------------------------
    // Command shift register
    // ---------------------------------------------------------------
    reg [31:0] shift;
    reg [5:0] bit_cnt;

    // Mode 0 and mode 3 both sample data on the rising clock edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            shift <= 32'h00000000;
            bit_cnt <= 6'h00;
        end else if (cs_fall) begin
            bit_cnt <= 6'h00;
        end else if (~cs_n_s && sck_rise) begin
            // Only the first 32 bits are kept; later bits are ignored
            if (bit_cnt < `BSE_CMD_BITS) begin
                shift <= {shift[30:0], si_s};
            end
            if (bit_cnt != `BSE_CNT_MAX) begin
                bit_cnt <= bit_cnt + 6'h01;
            end
        end
    end

    wire [7:0] opcode = shift[31:24];
    wire [23:0] addr = shift[23:0];
    wire framed = (bit_cnt >= `BSE_CMD_BITS);

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    // Binary mode has a leading dummy bit, standard mode trails 9 bits
    wire [AW-1:0] page_index_bits = binary_page_mode_i ?
        addr[`BSE_BIN_PAGE_MSB:`BSE_BIN_PAGE_LSB] :
        addr[`BSE_STD_PAGE_MSB:`BSE_STD_PAGE_LSB];

    wire [11:0] block_num = page_index_bits[14:3];
    wire [4:0] sector_num = page_index_bits[14:10];

    reg [AW-1:0] next_first;
    reg [AW-1:0] next_last;
    reg [23:0] next_pulse;

    always @* begin
        next_first = {AW{1'b0}};
        next_last = {AW{1'b0}};
        next_pulse = BE_CNT;
        if (opcode == `BSE_OP_BLOCK_ERASE) begin
            // Aligned group of eight pages
            next_first = page_index_bits & ~`BSE_BLOCK_OFFSET_MASK;
            next_last = page_index_bits | `BSE_BLOCK_OFFSET_MASK;
            next_pulse = BE_CNT;
        end else begin
            next_pulse = SE_CNT;
            if (block_num == `BSE_SEC0A_BLOCK) begin
                next_first = `BSE_SEC0A_FIRST;
                next_last = `BSE_SEC0A_LAST;
            end else if (sector_num == `BSE_SEC_ZERO) begin
                // Any page of 8..1023 lies in sector 0b
                next_first = `BSE_SEC0B_FIRST;
                next_last = `BSE_SEC0B_LAST;
            end else begin
                next_first = page_index_bits & ~`BSE_SECTOR_OFFSET_MASK;
                next_last = page_index_bits | `BSE_SECTOR_OFFSET_MASK;
            end
        end
    end

    wire is_erase = (opcode == `BSE_OP_BLOCK_ERASE) || (opcode == `BSE_OP_SECTOR_ERASE);

    // ---------------------------------------------------------------
    // Erase sequencer
    // ---------------------------------------------------------------
    reg [2:0] state;
    reg [AW-1:0] cur_page;
    reg [AW-1:0] last_page;
    reg [23:0] pulse_cnt;
    reg fail;

    wire [DW-1:0] mem_rdata;
    wire idle = (state == ST_IDLE);
    // A weak page drops its erase write, so the read-back check catches it
    wire weak_hit = weak_en_i && (cur_page == weak_page_i);
    wire mem_we = (state == ST_WRITE) ? ~weak_hit : (idle & load_we_i);
    wire [AW-1:0] mem_waddr = idle ? load_page_i : cur_page;
    wire [DW-1:0] mem_wdata = idle ? load_data_i : `BSE_ERASED_BYTE;
    wire [AW-1:0] mem_raddr = idle ? peek_page_i : cur_page;

    bse_page_mem #(
        .WIDTH(DW),
        .AW(AW)
    ) u_mem (
        .clk_i(clk_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .raddr_i(mem_raddr),
        .rdata_o(mem_rdata)
    );

    // Commands arriving while busy are dropped; the host must poll first
    wire start = idle && cs_rise && framed && is_erase;

    always @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            cur_page <= {AW{1'b0}};
            last_page <= {AW{1'b0}};
            pulse_cnt <= 24'h000000;
            fail <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        cur_page <= next_first;
                        last_page <= next_last;
                        pulse_cnt <= next_pulse;
                        fail <= 1'b0;
                        state <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (pulse_cnt == 24'h000001) begin
                        state <= ST_WRITE;
                    end
                    pulse_cnt <= pulse_cnt - 24'h000001;
                end
                ST_WRITE: begin
                    state <= ST_READ;
                end
                ST_READ: begin
                    state <= ST_CHECK;
                end
                ST_CHECK: begin
                    // Read-back must be all ones
                    if (mem_rdata != `BSE_ERASED_BYTE) begin
                        fail <= 1'b1;
                    end
                    if (cur_page == last_page) begin
                        state <= ST_IDLE;
                    end else begin
                        cur_page <= cur_page + {{(AW-1){1'b0}}, 1'b1};
                        state <= ST_WRITE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    wire last_fail = fail | (mem_rdata != `BSE_ERASED_BYTE);
    wire finishing = (state == ST_CHECK) && (cur_page == last_page);

    // ---------------------------------------------------------------
    // Status outputs
    // ---------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ready_busy_flag_o <= `BSE_RST_READY;
            erase_program_error_flag_o <= `BSE_RST_ERROR;
            peek_data_o <= {DW{1'b0}};
        end else begin
            if (start) begin
                ready_busy_flag_o <= 1'b0;
            end else if (finishing) begin
                ready_busy_flag_o <= 1'b1;
            end
            // Flag reflects the outcome of the most recent erase
            if (finishing) begin
                erase_program_error_flag_o <= last_fail;
            end
            if (idle) begin
                peek_data_o <= mem_rdata;
            end
        end
    end
endmodule // bse_erase

// ### verification/bse_spi_host.sv
// Serial host model that frames erase commands
`timescale 1ns/1ps
module bse_spi_host #(
    parameter HALF_NS = 80
) (
    output logic sck_o, // Serial clock, idle low
    output logic cs_n_o, // Chip select, active low
    output logic si_o // Serial data out
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end

    // Offset keeps the link out of phase with the block clock
    task automatic send(input logic [31:0] w, input int n);
        #3;
        cs_n_o = 1'b0;
        for (int i = 31; i > 31 - n; i--) begin
            si_o = w[i];
            #(HALF_NS);
            sck_o = 1'b1;
            #(HALF_NS);
            sck_o = 1'b0;
        end
        #(HALF_NS);
        cs_n_o = 1'b1;
        // Released line must not keep its last value
        si_o = ~si_o;
        #(HALF_NS);
    endtask
endmodule // bse_spi_host

// ### verification/bse_erase_assertions.sv
// Port checker for the erase decoder
`timescale 1ns/1ps
module bse_erase_assertions #(
    parameter CLK_PERIOD_NS = 8,
    parameter SECTOR_ERASE_TIME_NS = 8000
) (
    input wire clk_i, // Block clock
    input wire rst_i, // Reset
    input wire cs_n_i, // Chip select pin
    input wire weak_en_i, // Fault enable
    input wire ready_busy_flag_o, // Ready flag
    input wire erase_program_error_flag_o // Error flag
);
    localparam int BUSY_LIMIT = SECTOR_ERASE_TIME_NS / CLK_PERIOD_NS + 3 * 1024 + 4;
    logic [15:0] busy_cnt;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence start_seen;
        $fell(ready_busy_flag_o);
    endsequence
    sequence busy_run;
        !ready_busy_flag_o [*8];
    endsequence

    always @(posedge clk_i) begin
        if (rst_i || ready_busy_flag_o) begin
            busy_cnt <= 16'h0000;
        end else begin
            busy_cnt <= busy_cnt + 16'h0001;
        end
    end

    a_reset_state: assert property ($fell(rst_i) |-> (ready_busy_flag_o && !erase_program_error_flag_o) [*3])
        else $error("flags wrong after reset");
    a_start_on_cs: assert property (start_seen |-> cs_n_i && !$past(cs_n_i, 8))
        else $error("busy without chip select rise");
    a_busy_min: assert property (start_seen |-> busy_run ##1 busy_run ##1 busy_run)
        else $error("busy too short");
    a_busy_bound: assert property (busy_cnt <= BUSY_LIMIT)
        else $error("erase overran its time");
    a_error_at_end: assert property ($rose(erase_program_error_flag_o) |-> $rose(ready_busy_flag_o))
        else $error("error set before erase end");
    a_error_fault_only: assert property ($rose(erase_program_error_flag_o) |-> weak_en_i)
        else $error("error without failing page");
    a_error_moves: assert property ($changed(erase_program_error_flag_o)
        |-> $rose(ready_busy_flag_o) or ##[0:2] !ready_busy_flag_o)
        else $error("error changed outside erase");
    a_idle_no_start: assert property (ready_busy_flag_o && cs_n_i && $past(cs_n_i, 8) |=> ready_busy_flag_o)
        else $error("erase started without frame");
endmodule // bse_erase_assertions

// ### verification/testbench.sv
// Self-checking bench for the erase decoder
`timescale 1ns/1ps
module testbench;
    logic clk_i, rst_i, bin_mode, weak_en, load_we;
    logic [14:0] weak_page, load_page, peek_page;
    logic [7:0] load_data;
    wire sck, cs_n, si, ready, error;
    wire [7:0] peek_data;
    int fails, tests_run, cycles;

    bse_spi_host u_bse_spi_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si));
    // Short erase pulses keep the run small
    bse_erase #(.BLOCK_ERASE_TIME_NS(80), .SECTOR_ERASE_TIME_NS(80)) u_bse_erase (
        .clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .binary_page_mode_i(bin_mode), .weak_en_i(weak_en), .weak_page_i(weak_page),
        .load_we_i(load_we), .load_page_i(load_page), .load_data_i(load_data),
        .peek_page_i(peek_page), .peek_data_o(peek_data), .ready_busy_flag_o(ready),
        .erase_program_error_flag_o(error));

    // ---------------------------------------------------------------
    // Clock, timeout and helpers
    // ---------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            fails = fails + 1;
            finish_test();
        end
    end

    task finish_test();
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function logic [31:0] cmd(input logic [7:0] op, input logic [14:0] p, input logic b);
        return b ? {op, 1'b0, p, 8'h00} : {op, p, 9'h000};
    endfunction

    task load(input logic [14:0] p);
        @(posedge clk_i);
        load_we <= 1'b1;
        load_page <= p;
        load_data <= 8'h00;
        @(posedge clk_i);
        load_we <= 1'b0;
    endtask

    task peek(input logic [14:0] p, input logic [7:0] exp);
        @(posedge clk_i);
        peek_page <= p;
        repeat (4) @(posedge clk_i);
        #1 check(peek_data, exp);
    endtask

    task wait_ready();
        int k;
        k = 0;
        while (ready !== 1'b1 && k < 4000) begin
            @(negedge clk_i);
            k++;
        end
        check(ready, 8'h01);
    endtask

    task run(input logic [31:0] w, input int n, input logic busy);
        int k;
        u_bse_spi_host.send(w, n);
        k = 0;
        while (ready === 1'b1 && k < 40) begin
            @(negedge clk_i);
            k++;
        end
        check(!ready, busy);
        wait_ready();
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task unit(input logic [7:0] op, input logic b, input logic [14:0] p, lo, hi, out);
        load(lo);
        load(hi);
        load(out);
        bin_mode <= b;
        run(cmd(op, p, b), 32, 1'b1);
        peek(lo, 8'hff);
        peek(hi, 8'hff);
        peek(out, 8'h00);
        check(error, 8'h00);
    endtask

    task t_block();
        unit(8'h50, 1'b0, 15'h0013, 15'h0010, 15'h0017, 15'h0018);
        unit(8'h50, 1'b1, 15'h7ffd, 15'h7ff8, 15'h7fff, 15'h7ff7);
        unit(8'h50, 1'b0, 15'h0007, 15'h0000, 15'h0007, 15'h0008);
    endtask

    task t_sector();
        unit(8'h7c, 1'b0, 15'h0005, 15'h0000, 15'h0007, 15'h0008);
        unit(8'h7c, 1'b1, 15'h03f0, 15'h0008, 15'h03ff, 15'h0400);
        unit(8'h7c, 1'b0, 15'h05a5, 15'h0400, 15'h07ff, 15'h0800);
        unit(8'h7c, 1'b1, 15'h7d55, 15'h7c00, 15'h7fff, 15'h7bff);
    endtask

    task t_fault();
        load(15'h0003);
        load(15'h0020);
        bin_mode <= 1'b0;
        weak_page <= 15'h0020;
        weak_en <= 1'b1;
        run(cmd(8'h50, 15'h0020, 1'b0), 32, 1'b1);
        check(error, 8'h01);
        weak_page <= 15'h0003;
        run(cmd(8'h7c, 15'h0000, 1'b0), 32, 1'b1);
        check(error, 8'h01);
        weak_en <= 1'b0;
        run(cmd(8'h50, 15'h0020, 1'b0), 32, 1'b1);
        check(error, 8'h00);
    endtask

    task t_refused();
        load(15'h0040);
        load(15'h0048);
        run(cmd(8'h50, 15'h0040, 1'b0), 24, 1'b0);
        run(cmd(8'h81, 15'h0040, 1'b0), 32, 1'b0);
        peek(15'h0040, 8'h00);
        run(cmd(8'h7c, 15'h0800, 1'b0), 0, 1'b0);
        u_bse_spi_host.send(cmd(8'h7c, 15'h0800, 1'b0), 32);
        u_bse_spi_host.send(cmd(8'h50, 15'h0048, 1'b0), 32);
        check(ready, 8'h00);
        wait_ready();
        peek(15'h0048, 8'h00);
    endtask

    initial begin
        rst_i = 1'b1;
        bin_mode = 1'b0;
        weak_en = 1'b0;
        weak_page = 15'h0000;
        load_we = 1'b0;
        load_page = 15'h0000;
        load_data = 8'h00;
        peek_page = 15'h0000;
        fails = 0;
        tests_run = 0;
        cycles = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_block();
        t_sector();
        t_fault();
        t_refused();
        finish_test();
    end
endmodule // testbench

bind bse_erase bse_erase_assertions #(.CLK_PERIOD_NS(CLK_PERIOD_NS), .SECTOR_ERASE_TIME_NS(SECTOR_ERASE_TIME_NS))
    u_bse_erase_assertions (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .weak_en_i(weak_en_i),
    .ready_busy_flag_o(ready_busy_flag_o), .erase_program_error_flag_o(erase_program_error_flag_o));
